// ===== sbac_pkg.sv
// Constants, register map and carrier types of the buffer admission controller.
// Assumes one 50 MHz clock shared with the receive ports, queues and scheduler.
package sbac_pkg;
  localparam int NPORT = 10;
  localparam int NFAST = 8;
  localparam logic [3:0] CPU_PORT = 4'h8;
  localparam logic [3:0] UPLINK_PORT = 4'h9;
  localparam int SLOT_W = 10;
  localparam int QB_W = 16;
  localparam int PCT_W = 7;
  localparam int LEN_W = 12;
  localparam int CR_W = 28;
  localparam int NBKT = 20;
  localparam int BKT_RX0 = 4;
  localparam int BKT_TX0 = 12;
  // Line rates in Mbps and the clock in MHz give bits earned per clock.
  localparam int CLK_MHZ = 50;
  localparam int UPLINK_MBPS = 1000;
  localparam int FAST_MBPS = 100;
  localparam int SHAPE_UNIT = UPLINK_MBPS / CLK_MHZ;
  localparam int RC_UNIT = FAST_MBPS / CLK_MHZ;
  localparam int RATE_DEN_SH = 6;
  localparam int BYTE_SH = 3;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_LEVEL_ONE = 8'h04;
  localparam logic [7:0] A_LEVEL_TWO = 8'h08;
  localparam logic [7:0] A_PCT_A = 8'h0C;
  localparam logic [7:0] A_PCT_B = 8'h10;
  localparam logic [7:0] A_CLS_LOW = 8'h14;
  localparam logic [7:0] A_CLS_MID = 8'h18;
  localparam logic [7:0] A_CLS_HIGH = 8'h1C;
  localparam logic [7:0] A_SHARED = 8'h20;
  localparam logic [7:0] A_FAST_RES = 8'h24;
  localparam logic [7:0] A_CPU_RES = 8'h28;
  localparam logic [7:0] A_UP_RES = 8'h2C;
  localparam logic [7:0] A_FC = 8'h30;
  localparam logic [7:0] A_MC_THR = 8'h34;
  localparam logic [7:0] A_BKT_SEL = 8'h38;
  localparam logic [7:0] A_BKT_DATA = 8'h3C;
  localparam logic [7:0] A_STATUS = 8'h40;
  localparam logic [7:0] A_MC_CNT = 8'h44;
  localparam logic [7:0] A_SHARED_USED = 8'h48;
  localparam int F_HALF = 16;
  localparam int F_LOWTHR = 16;
  localparam int F_SECOND = 8;
  localparam int F_BKT_EN = 7;
  localparam int F_BURST = 16;
  localparam int F_MCP = 16;
  localparam int F_TEMPF = 17;
  localparam logic [SLOT_W-1:0] RES_RST = 10'h010;
  typedef enum logic [1:0] {SBAC_CLASS = 2'h0, SBAC_SHARED = 2'h1, SBAC_PORT = 2'h3,
                            SBAC_NONE = 2'h2} sbac_region_t;
  typedef struct packed {
    logic valid;
    logic [3:0] src;
    logic [3:0] dst;
    logic [1:0] queue;
    logic [2:0] prio;
    logic high_drop;
    logic mcast;
    logic unicast_congestion_level;
    logic [QB_W-1:0] queue_byte_count;
  } sbac_req_t;
  typedef struct packed {
    logic valid;
    logic drop;
    sbac_region_t region;
    logic [1:0] cls;
    logic [3:0] src;
    logic mcast;
  } sbac_dec_t;
  typedef struct packed {
    logic valid;
    sbac_region_t region;
    logic [1:0] cls;
    logic [3:0] src;
    logic mcast;
  } sbac_rel_t;
  typedef struct packed {
    logic valid;
    logic [3:0] port;
    logic [LEN_W-1:0] len;
  } sbac_tx_t;
endpackage

// ===== sbac_top.sv
// Admission, early drop, shaping, rate control and pause logic of the switch.
// Assumes requests, releases and sent-frame events come from logic on pclk.
`timescale 1ns/10ps
module sbac_top import sbac_pkg::*; #(
  parameter int TEMP_SLOTS = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_arrive,
  output logic temp_full,
  input wire sbac_req_t req,
  output sbac_dec_t dec,
  input wire sbac_rel_t rel,
  input wire sbac_tx_t up_tx,
  input wire sbac_tx_t rx_evt,
  input wire sbac_tx_t tx_evt,
  output logic [NBKT-1:0] allow,
  output logic [NPORT-1:0] pause_frame,
  output logic [NPORT-1:0] backpressure
);
  // ****************************************
  // Configuration registers
  // ****************************************
  logic [NPORT-1:0] fc_en, half_dup;
  logic [QB_W-1:0] level_one, level_two;
  logic [PCT_W-1:0] pct_x, pct_y, pct_z, pct_b;
  logic [SLOT_W-1:0] class_res [0:3];
  logic [SLOT_W-1:0] shared_size, fast_res, cpu_res, up_res, xoff_level, low_thr, mc_thr;
  logic [4:0] bkt_sel;
  logic [PCT_W-1:0] bkt_rate [0:NBKT-1];
  logic [NBKT-1:0] bkt_en;
  logic [15:0] bkt_burst [0:NBKT-1];
  logic [SLOT_W-1:0] class_used [0:3];
  logic [SLOT_W-1:0] port_used [0:NPORT-1];
  logic [SLOT_W-1:0] shared_used, mc_cnt;
  logic [5:0] temp_used;
  logic [NPORT-1:0] xoff;
  logic mc_pause;
  logic [15:0] lfsr;
  logic wr, rd;

  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;

  function automatic logic [SLOT_W-1:0] port_res(input logic [3:0] p);
    if (p == CPU_PORT) return cpu_res;
    if (p == UPLINK_PORT) return up_res;
    return fast_res;
  endfunction

  // Scales a 7-bit random value into 0..99 before comparing with a percentage.
  function automatic logic pct_hit(input logic [PCT_W-1:0] pct, input logic [6:0] rnd);
    logic [13:0] sc;
    sc = 14'(rnd) * 14'h64;
    return sc[13:7] < pct;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fc_en <= '0;
      half_dup <= '0;
      level_one <= '1;
      level_two <= '1;
      pct_x <= '0;
      pct_y <= '0;
      pct_z <= '0;
      pct_b <= '0;
      class_res <= '{default: RES_RST};
      shared_size <= RES_RST;
      fast_res <= RES_RST;
      cpu_res <= RES_RST;
      up_res <= RES_RST;
      xoff_level <= RES_RST;
      low_thr <= '0;
      mc_thr <= RES_RST;
      bkt_sel <= '0;
      bkt_rate <= '{default: '0};
      bkt_en <= '0;
      bkt_burst <= '{default: '0};
    end else if (wr) begin
      unique case (paddr)
        A_CTRL: begin
          fc_en <= pwdata[NPORT-1:0];
          half_dup <= pwdata[F_HALF+:NPORT];
        end
        A_LEVEL_ONE: level_one <= pwdata[QB_W-1:0];
        A_LEVEL_TWO: level_two <= pwdata[QB_W-1:0];
        A_PCT_A: begin
          pct_x <= pwdata[PCT_W-1:0];
          pct_y <= pwdata[F_SECOND+:PCT_W];
        end
        A_PCT_B: begin
          pct_z <= pwdata[PCT_W-1:0];
          pct_b <= pwdata[F_SECOND+:PCT_W];
        end
        A_CLS_LOW: class_res[1] <= pwdata[SLOT_W-1:0];
        A_CLS_MID: class_res[2] <= pwdata[SLOT_W-1:0];
        A_CLS_HIGH: class_res[3] <= pwdata[SLOT_W-1:0];
        A_SHARED: shared_size <= pwdata[SLOT_W-1:0];
        A_FAST_RES: fast_res <= pwdata[SLOT_W-1:0];
        A_CPU_RES: cpu_res <= pwdata[SLOT_W-1:0];
        A_UP_RES: up_res <= pwdata[SLOT_W-1:0];
        A_FC: begin
          xoff_level <= pwdata[SLOT_W-1:0];
          low_thr <= pwdata[F_LOWTHR+:SLOT_W];
        end
        A_MC_THR: mc_thr <= pwdata[SLOT_W-1:0];
        A_BKT_SEL: bkt_sel <= pwdata[4:0];
        A_BKT_DATA: begin
          if (bkt_sel < 5'(NBKT)) begin
            bkt_rate[bkt_sel] <= pwdata[PCT_W-1:0];
            bkt_en[bkt_sel] <= pwdata[F_BKT_EN];
            bkt_burst[bkt_sel] <= pwdata[F_BURST+:16];
          end
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // APB read side
  // ****************************************
  // Read data is staged in the setup cycle so the access phase needs no wait.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      if (rd) begin
        prdata <= '0;
        unique case (paddr)
          A_CTRL: prdata <= 32'({half_dup, 6'h00, fc_en});
          A_LEVEL_ONE: prdata <= 32'(level_one);
          A_LEVEL_TWO: prdata <= 32'(level_two);
          A_PCT_A: prdata <= 32'({pct_y, 1'b0, pct_x});
          A_PCT_B: prdata <= 32'({pct_b, 1'b0, pct_z});
          A_CLS_LOW: prdata <= 32'(class_res[1]);
          A_CLS_MID: prdata <= 32'(class_res[2]);
          A_CLS_HIGH: prdata <= 32'(class_res[3]);
          A_SHARED: prdata <= 32'(shared_size);
          A_FAST_RES: prdata <= 32'(fast_res);
          A_CPU_RES: prdata <= 32'(cpu_res);
          A_UP_RES: prdata <= 32'(up_res);
          A_FC: prdata <= 32'({low_thr, 6'h00, xoff_level});
          A_MC_THR: prdata <= 32'(mc_thr);
          A_BKT_SEL: prdata <= 32'(bkt_sel);
          A_BKT_DATA: if (bkt_sel < 5'(NBKT))
            prdata <= {bkt_burst[bkt_sel], 8'h00, bkt_en[bkt_sel], bkt_rate[bkt_sel]};
          A_STATUS: prdata <= 32'({temp_full, mc_pause, 6'h00, xoff});
          A_MC_CNT: prdata <= 32'(mc_cnt);
          A_SHARED_USED: prdata <= 32'(shared_used);
          default: prdata <= '0;
        endcase
      end
    end
  end

  // ****************************************
  // Admission decision
  // ****************************************
  logic [1:0] cls;
  logic [SLOT_W-1:0] pres, pused;
  logic cls_room, sh_room, pt_room, eligible, wred_drop, be_drop;
  sbac_region_t region;

  always_comb begin
    // reservation pair from the upper priority bits
    cls = req.prio[2:1];
    pres = port_res(req.src);
    pused = port_used[req.src];
    cls_room = (cls != 2'h0) && (class_used[cls] < class_res[cls]);
    sh_room = shared_used < shared_size;
    pt_room = pused < pres;
    region = cls_room ? SBAC_CLASS : sh_room ? SBAC_SHARED : pt_room ? SBAC_PORT : SBAC_NONE;
    // strict queue of fast ports, top three uplink queues
    eligible = (req.dst < 4'(NFAST) && req.queue == 2'h1) || (req.dst == UPLINK_PORT && req.queue != 2'h0);
    if (eligible && req.queue_byte_count > level_two)
      wred_drop = req.high_drop | pct_hit(pct_z, lfsr[6:0]);
    else if (eligible && req.queue_byte_count > level_one)
      wred_drop = pct_hit(req.high_drop ? pct_x : pct_y, lfsr[6:0]);
    else
      wred_drop = 1'b0;
    // scarcity drops only without flow control
    be_drop = 1'b0;
    if (req.queue == 2'h0 && !fc_en[req.src]) begin
      if (!pt_room) be_drop = 1'b1;
      if (req.unicast_congestion_level && !sh_room && pct_hit(pct_b, lfsr[14:8])) be_drop = 1'b1;
      if (req.unicast_congestion_level && (pres - pused) < low_thr) be_drop = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec <= '0;
    end else begin
      dec.valid <= req.valid;
      // total drop on exhausted resources; early drop regardless of flow control
      dec.drop <= (region == SBAC_NONE) | wred_drop | be_drop;
      dec.region <= region;
      dec.cls <= cls;
      dec.src <= req.src;
      dec.mcast <= req.mcast;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lfsr <= 16'hACE1;
    else lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
  end

  // ****************************************
  // Buffer accounting
  // ****************************************
  logic acc;
  assign acc = req.valid & ~((region == SBAC_NONE) | wred_drop | be_drop);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      class_used <= '{default: '0};
      port_used <= '{default: '0};
      shared_used <= '0;
      mc_cnt <= '0;
    end else begin
      for (int i = 1; i < 4; i++)
        class_used[i] <= class_used[i] + SLOT_W'(acc && region == SBAC_CLASS && cls == 2'(i))
                                       - SLOT_W'(rel.valid && rel.region == SBAC_CLASS && rel.cls == 2'(i));
      for (int i = 0; i < NPORT; i++)
        port_used[i] <= port_used[i] + SLOT_W'(acc && region == SBAC_PORT && req.src == 4'(i))
                                     - SLOT_W'(rel.valid && rel.region == SBAC_PORT && rel.src == 4'(i));
      shared_used <= shared_used + SLOT_W'(acc && region == SBAC_SHARED)
                                 - SLOT_W'(rel.valid && rel.region == SBAC_SHARED);
      mc_cnt <= mc_cnt + SLOT_W'(acc && req.mcast) - SLOT_W'(rel.valid && rel.mcast);
    end
  end

  // Temporary region holds frames between arrival and their decision.
  logic [5:0] next_temp;
  assign next_temp = temp_used + 6'(rx_arrive) - 6'(req.valid);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_used <= '0;
      temp_full <= 1'b0;
    end else begin
      temp_used <= next_temp;
      temp_full <= next_temp >= 6'(TEMP_SLOTS);
    end
  end

  // ****************************************
  // Flow control
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xoff <= '0;
      mc_pause <= 1'b0;
      pause_frame <= '0;
      backpressure <= '0;
    end else begin
      for (int i = 0; i < NPORT; i++) begin
        // pause at the programmed slot count
        if (port_used[i] >= xoff_level && xoff_level != '0) xoff[i] <= 1'b1;
        // release only when every slot is free
        else if (port_used[i] == '0) xoff[i] <= 1'b0;
      end
      if (mc_cnt > mc_thr) mc_pause <= 1'b1;
      else if (mc_cnt < mc_thr) mc_pause <= 1'b0;
      // pause frames on full duplex, backpressure on half duplex
      pause_frame <= fc_en & (xoff | {NPORT{mc_pause}}) & ~half_dup;
      backpressure <= fc_en & (xoff | {NPORT{mc_pause}}) & half_dup;
    end
  end

  // ****************************************
  // Shapers and rate control buckets
  // ****************************************
  // Buckets 0-3 shape uplink queues; 4-11 and 12-19 limit fast-port rx and tx.
  // Credit is in 1/64 bit; a disabled bucket always allows.
  logic signed [CR_W-1:0] credit [0:NBKT-1];
  logic signed [CR_W-1:0] next_credit [0:NBKT-1];

  always_comb begin
    for (int i = 0; i < NBKT; i++) begin
      // earn setting/64 of the line rate
      next_credit[i] = credit[i] + CR_W'(bkt_rate[i]) * CR_W'(i < BKT_RX0 ? SHAPE_UNIT : RC_UNIT);
      if (i < BKT_RX0 && up_tx.valid && up_tx.port == 4'(i))
        next_credit[i] = next_credit[i] - (CR_W'(up_tx.len) <<< (BYTE_SH + RATE_DEN_SH));
      if (i >= BKT_RX0 && i < BKT_TX0 && rx_evt.valid && rx_evt.port == 4'(i - BKT_RX0))
        next_credit[i] = next_credit[i] - (CR_W'(rx_evt.len) <<< (BYTE_SH + RATE_DEN_SH));
      if (i >= BKT_TX0 && tx_evt.valid && tx_evt.port == 4'(i - BKT_TX0))
        next_credit[i] = next_credit[i] - (CR_W'(tx_evt.len) <<< (BYTE_SH + RATE_DEN_SH));
      if (next_credit[i] > $signed(CR_W'(bkt_burst[i]) <<< (BYTE_SH + RATE_DEN_SH)))
        next_credit[i] = CR_W'(bkt_burst[i]) <<< (BYTE_SH + RATE_DEN_SH);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      credit <= '{default: '0};
      allow <= '1;
    end else begin
      for (int i = 0; i < NBKT; i++) begin
        credit[i] <= bkt_en[i] ? next_credit[i] : '0;
        // own bucket per uplink queue and per fast-port rx and tx; hold back while in debt
        allow[i] <= ~bkt_en[i] | (next_credit[i] >= 0);
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_port_full(int p);
    xoff_level != '0 && port_used[p] >= xoff_level;
  endsequence

  a_level_two_drop: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && eligible && req.high_drop && req.queue_byte_count > level_two |=> dec.drop)
    else $error("high-drop frame above level two was kept");
  a_no_room_drop: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && !cls_room && !sh_room && !pt_room |=> dec.valid && dec.drop)
    else $error("frame kept with no buffer room");
  a_low_prio_class: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && req.prio < 3'h2 |=> dec.region != SBAC_CLASS)
    else $error("priority 0 or 1 placed in a class region");
  a_alloc_order: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && !cls_room && sh_room |=> dec.region == SBAC_SHARED)
    else $error("shared pool skipped");
  a_be_fc_exempt: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && fc_en[req.src] && !wred_drop && region != SBAC_NONE |=> !dec.drop)
    else $error("flow-controlled frame dropped for scarcity");
  a_pause_set: assert property (@(posedge pclk) disable iff (!presetn)
    s_port_full(3) ##1 fc_en[3] && !half_dup[3] |=> pause_frame[3])
    else $error("pause not raised on full port");
  a_pause_hold: assert property (@(posedge pclk) disable iff (!presetn)
    xoff[3] && port_used[3] != '0 |=> xoff[3])
    else $error("pause released with slots in use");
  a_mc_pause: assert property (@(posedge pclk) disable iff (!presetn)
    mc_cnt > mc_thr |=> mc_pause)
    else $error("multicast pause missing");
  a_half_dup_bp: assert property (@(posedge pclk) disable iff (!presetn)
    fc_en[3] && xoff[3] |=> ($past(half_dup[3]) ? backpressure[3] && !pause_frame[3] :
      pause_frame[3] && !backpressure[3])) else $error("pause carried on the wrong signal");
  a_shaper_hold: assert property (@(posedge pclk) disable iff (!presetn)
    bkt_en[0] && next_credit[0] < 0 |=> !allow[0])
    else $error("shaper allowed while in debt");
  a_temp_full: assert property (@(posedge pclk) disable iff (!presetn)
    next_temp >= 6'(TEMP_SLOTS) |=> temp_full)
    else $error("temporary region full not flagged");
endmodule // sbac_top

// ===== sbac_link_partner.sv
// Link partner model: hands classified frames to the admission block.
// Assumes req is sampled on rising pclk and pause_frame is a level per port.
`timescale 1ns/10ps
module sbac_link_partner import sbac_pkg::*; (
  input wire logic pclk,
  input wire logic [NPORT-1:0] pause_frame,
  output sbac_req_t req
);
  initial req = '0;
  task automatic send(input sbac_req_t r, input int gap);
    int n;
    n = 0;
    repeat (gap) @(posedge pclk);
    while (pause_frame[r.src] === 1'b1 && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    req <= r;
    @(posedge pclk);
    // Idle fields are scrambled so that a stale request can never pass for a new one.
    req <= {1'b0, ~r[$bits(sbac_req_t)-2:0]};
  endtask
endmodule // sbac_link_partner

// ===== switch_buffer_admission_control_tb_top.sv
// Self-checking bench of the admission block with a reference occupancy model.
// Assumes the partner model drives req and the bench drives APB and releases.
`timescale 1ns/10ps
module switch_buffer_admission_control_tb_top import sbac_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready;
  logic pslverr;
  logic temp_full;
  sbac_req_t req;
  sbac_dec_t dec;
  sbac_rel_t rel = '0;
  sbac_tx_t evt = '0;
  logic rx_arrive = 1'b0;
  localparam int TEMP_N = 32;
  logic [NBKT-1:0] allow;
  logic [NPORT-1:0] pause_frame;
  logic [NPORT-1:0] backpressure;
  int bad_count = 0;
  int num_checks = 0;
  int seed = 48191;
  int shared_used = 0;
  int shr_size = 16;
  int cls_used[4] = '{default: 0};
  int port_used[NPORT] = '{default: 0};

  sbac_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_arrive(rx_arrive), .temp_full(temp_full), .req(req), .dec(dec), .rel(rel), .up_tx(evt),
    .rx_evt(evt), .tx_evt(evt), .allow(allow), .pause_frame(pause_frame),
    .backpressure(backpressure));
  sbac_link_partner p_u (.pclk(pclk), .pause_frame(pause_frame), .req(req));

  always #10 pclk = ~pclk;

  // ****************************************
  // Shared tasks and the reference model
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk({pready, pslverr}, 32'h2, "apb answer");
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Class region first, then the shared pool, then the source-port region.
  function sbac_region_t exp_reg(input logic [2:0] p);
    if (p[2:1] != 2'h0 && cls_used[p[2:1]] < 16) return SBAC_CLASS;
    if (shared_used < shr_size) return SBAC_SHARED;
    return SBAC_PORT;
  endfunction

  task frame(input logic [3:0] s, input logic [3:0] d, input logic [1:0] qu, input logic [2:0] p,
             input logic h, input logic [15:0] b, input logic xd);
    sbac_region_t er;
    er = exp_reg(p);
    // The frame enters the temporary region a cycle before it is classified.
    rx_arrive <= 1'b1;
    @(posedge pclk);
    rx_arrive <= 1'b0;
    p_u.send({1'b1, s, d, qu, p, h, 1'b0, 1'b0, b}, 0);
    @(posedge pclk);
    chk(dec.valid, 1'b1, "decision missing");
    chk(dec.drop, xd, "drop decision");
    chk(temp_full, 1'b0, "temporary region full");
    if (xd == 1'b0) begin
      chk(dec.region, er, "region");
      chk(dec.cls, p[2:1], "class");
      if (er == SBAC_CLASS) cls_used[p[2:1]]++;
      else if (er == SBAC_SHARED) shared_used++;
      else port_used[s]++;
    end
  endtask

  task rel_port;
    rel <= {1'b1, SBAC_PORT, 2'h0, 4'h3, 1'b0};
    @(posedge pclk);
    rel <= {1'b0, SBAC_CLASS, 2'h3, 4'hC, 1'b1};
    port_used[3]--;
  endtask

  task wait_pause(input logic v);
    int n;
    n = 0;
    while (pause_frame[3] !== v && n < 8) begin
      @(posedge pclk);
      n++;
    end
    chk(pause_frame[3], v, "pause level");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_LEVEL_ONE, 32'h0, q);
    chk(q, 32'h0000FFFF, "level one reset");
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, A_CLS_LOW + 8'(4 * i), 32'h0, q);
      chk(q, 32'h00000010, "reservation reset");
    end
    apb(1'b1, A_CPU_RES, 32'h00000155, q);
    apb(1'b0, A_CPU_RES, 32'h0, q);
    chk(q, 32'h00000155, "cpu reservation");
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, (i == 0) ? 8'hFC : A_STATUS, 32'hFFFFFFFF, q);
      apb(1'b0, (i == 0) ? 8'hFC : A_STATUS, 32'h0, q);
      chk(q, 32'h0, "read-only or unmapped");
    end
    for (int i = 0; i < 12; i++) begin
      frame(4'({$random(seed)} % 8), 4'h0, 2'h1, 3'($random(seed)), 1'b0, 16'($random(seed)) & 16'h7FFF, 1'b0);
    end
    apb(1'b1, A_CTRL, 32'h0000000A, q);
    apb(1'b1, A_LEVEL_TWO, 32'h00000100, q);
    apb(1'b1, A_PCT_B, 32'h00000064, q);
    frame(4'h1, 4'h0, 2'h1, 3'h6, 1'b1, 16'h0200, 1'b1);
    frame(4'h1, 4'h0, 2'h1, 3'h6, 1'b0, 16'h0200, 1'b1);
    frame(4'h1, 4'h0, 2'h1, 3'h6, 1'b1, 16'h0100, 1'b0);
    frame(4'h1, 4'h0, 2'h0, 3'h6, 1'b1, 16'h0200, 1'b0);
    frame(4'h1, 4'h9, 2'h3, 3'h6, 1'b1, 16'h0200, 1'b1);
    frame(4'h1, 4'h9, 2'h0, 3'h6, 1'b1, 16'h0200, 1'b0);
    apb(1'b1, A_PCT_B, 32'h0, q);
    frame(4'h1, 4'h0, 2'h1, 3'h6, 1'b0, 16'h0200, 1'b0);
    apb(1'b1, A_SHARED, 32'h0, q);
    shr_size = 0;
    apb(1'b1, A_FC, 32'h00000002, q);
    frame(4'h3, 4'h0, 2'h1, 3'h0, 1'b0, 16'h0000, 1'b0);
    frame(4'h3, 4'h0, 2'h1, 3'h0, 1'b0, 16'h0000, 1'b0);
    wait_pause(1'b1);
    chk(backpressure[3], 1'b0, "backpressure on full duplex");
    fork
      frame(4'h3, 4'h0, 2'h1, 3'h0, 1'b0, 16'h0000, 1'b0);
    join_none
    repeat (4) begin
      @(posedge pclk);
      chk(dec.valid, 1'b0, "frame sent while paused");
    end
    rel_port;
    repeat (4) @(posedge pclk);
    chk(pause_frame[3], 1'b1, "resume before all slots free");
    rel_port;
    wait_pause(1'b0);
    wait fork;
    apb(1'b1, A_FAST_RES, 32'h0, q);
    frame(4'h3, 4'h0, 2'h1, 3'h0, 1'b0, 16'h0000, 1'b1);
    frame(4'h5, 4'h0, 2'h0, 3'h4, 1'b0, 16'h0000, 1'b1);
    chk(32'(allow), 32'h000FFFFF, "disabled buckets allow");
    apb(1'b1, A_BKT_SEL, 32'h0, q);
    apb(1'b1, A_BKT_DATA, 32'h001000A0, q);
    apb(1'b1, A_BKT_SEL, 32'(BKT_TX0), q);
    apb(1'b1, A_BKT_DATA, 32'h001000C0, q);
    apb(1'b0, A_BKT_DATA, 32'h0, q);
    chk(q, 32'h001000C0, "bucket setting");
    repeat (70) @(posedge pclk);
    chk(allow[0], 1'b1, "shaper with saved credit");
    evt <= {1'b1, 4'h0, 12'h040};
    @(posedge pclk);
    evt <= '0;
    @(posedge pclk);
    chk({allow[12], allow[4], allow[0]}, 32'h2, "buckets after a 64-byte frame");
    // 512 bits owed, 128 saved, 10 earned per clock at setting 32: clear after 38 clocks.
    repeat (36) @(posedge pclk);
    chk(allow[0], 1'b0, "shaper released early");
    repeat (2) @(posedge pclk);
    chk(allow[0], 1'b1, "shaper not released");
    rx_arrive <= 1'b1;
    repeat (TEMP_N) @(posedge pclk);
    rx_arrive <= 1'b0;
    @(posedge pclk);
    chk(temp_full, 1'b1, "temporary region not full");
    stop_test;
  end

  // A hang is cut short well beyond the few hundred cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    stop_test;
  end
endmodule // switch_buffer_admission_control_tb_top
